// [design/vr_phase_mode_pkg.sv]
package vr_phase_mode_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] OC_FLAG_OFS = 8'h08;
	localparam logic [7:0] ZC_THR_OFS = 8'h0c;
	localparam logic [7:0] REF_OFS = 8'h10;

	// Status field positions, plus aux field positions in the ZC_THR and REF words
	localparam int ST_CFG_MAIN = 0;
	localparam int ST_CFG_AUX = 2;
	localparam int ST_PH_MAIN = 4;
	localparam int ST_EMU_MAIN = 6;
	localparam int ST_PH_AUX = 7;
	localparam int ST_EMU_AUX = 9;
	localparam int ST_SW_CLOSED = 10;
	localparam int ST_RUN_BIT = 11;
	localparam int ST_OC = 12;
	localparam int ZC_AUX_POS = 8;
	localparam int REF_AUX_POS = 8;

	// Reset values and the zero-cross threshold ceiling
	localparam logic [15:0] SLEW_CYC_RST = 16'h0064;
	localparam logic [5:0] ZC_THR_RST = 6'h20;
	localparam logic [5:0] ZC_THR_MAX = 6'h3f;

	// Analog levels as digitised codes
	localparam logic [11:0] OC_THRESH_MV = 12'd1500;

	// Timing
	localparam int CLK_MHZ = 250;
	localparam int BODY_DIODE_NS = 40;
	localparam int BODY_DIODE_CYC = (BODY_DIODE_NS * CLK_MHZ + 999) / 1000;
	localparam int MEAS_WIN_CYC = 32;
	localparam int STRAP_SETTLE_CYC = 8;

	typedef enum logic [1:0] {
		CFG_OFF = 2'b00,
		CFG_1PH = 2'b01,
		CFG_2PH = 2'b10,
		CFG_3PH = 2'b11
	} phase_cfg_t;

	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_RUN = 2'b11
	} strap_state_t;

	typedef struct packed {
		logic [1:0] phases;
		logic diode_emulation;
	} op_mode_t;

	typedef struct packed {
		logic power_state_bit_low0;
		logic power_state_bit_low1;
	} ps_cmd_t;

endpackage

// [design/vr_phase_mode_select.sv]
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps

module vr_phase_mode_select
	import vr_phase_mode_pkg::*;
#(
	parameter int VID_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic main_phase1_sense,
	input wire logic main_phase2_sense,
	input wire logic main_phase3_sense,
	input wire logic aux_phase1_sense,
	input wire logic aux_phase2_sense,
	input wire ps_cmd_t ps_cmd,
	input wire logic ps_cmd_valid,
	input wire logic [VID_W-1:0] vid_main,
	input wire logic [VID_W-1:0] vid_aux,
	input wire logic vid_valid,
	input wire logic [11:0] main_current_monitor,
	input wire logic [11:0] aux_current_monitor,
	input wire logic [1:0] vout_above_target,
	input wire logic [1:0] low_side_on,
	input wire logic [1:0] zero_cross_cmp,
	input wire logic [1:0] diode_fwd_cond,
	input wire logic [1:0] diode_rev_spike,
	output logic switching_enable,
	output logic [2:0] main_phase_en,
	output logic [1:0] aux_phase_en,
	output op_mode_t main_mode,
	output op_mode_t aux_mode,
	output logic feedback_switch_close,
	output logic aux_feedback_track,
	output logic [1:0] oc_detect,
	output logic [VID_W-1:0] ref_main,
	output logic [VID_W-1:0] ref_aux,
	output logic [1:0] decay_active,
	output logic [1:0] low_side_off_req,
	output logic [5:0] zc_thr_main,
	output logic [5:0] zc_thr_aux
);

	localparam int NSYNC = 13;

	// Two-stage synchronisers; stage one feeds stage two only
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	wire logic [NSYNC-1:0] async_in = {diode_rev_spike, diode_fwd_cond, zero_cross_cmp,
		vout_above_target, aux_phase2_sense, aux_phase1_sense, main_phase3_sense,
		main_phase2_sense, main_phase1_sense};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= async_in;
			sync2 <= sync1;
		end
	end

	wire logic [4:0] strap_s = sync2[4:0];
	wire logic [1:0] vabove_s = sync2[6:5];
	wire logic [1:0] zc_s = sync2[8:7];
	wire logic [1:0] fwd_s = sync2[10:9];
	wire logic [1:0] rev_s = sync2[12:11];

	// Strap capture: waits for the synchronisers to settle, then latches once
	strap_state_t strap_state;
	logic [3:0] settle_cnt;
	phase_cfg_t cfg_main;
	phase_cfg_t cfg_aux;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_state <= ST_WAIT;
			settle_cnt <= '0;
		end else begin
			case (strap_state)
				ST_WAIT: begin
					settle_cnt <= settle_cnt + 4'd1;
					if (settle_cnt == 4'(STRAP_SETTLE_CYC - 1)) begin
						strap_state <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: strap_state <= ST_RUN;
				ST_RUN: strap_state <= ST_RUN;
				default: strap_state <= ST_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_main <= CFG_OFF;
			cfg_aux <= CFG_OFF;
		end else if (strap_state == ST_SAMPLE) begin
			if (strap_s[0]) begin
				cfg_main <= CFG_OFF;
			end else if (strap_s[2] && strap_s[1]) begin
				cfg_main <= CFG_1PH;
			end else if (strap_s[2]) begin
				cfg_main <= CFG_2PH;
			end else begin
				cfg_main <= CFG_3PH;
			end
			if (strap_s[3]) begin
				cfg_aux <= CFG_OFF;
			end else if (strap_s[4]) begin
				cfg_aux <= CFG_1PH;
			end else begin
				cfg_aux <= CFG_2PH;
			end
		end
	end

	assign switching_enable = (strap_state == ST_RUN);

	// Phase count and conduction mode from config and power-state bits.
	// Code 10 has no defined mode and is treated like 11.
	function automatic op_mode_t pick_mode(phase_cfg_t cfg, ps_cmd_t ps);
		op_mode_t m;
		m.phases = 2'(cfg);
		m.diode_emulation = 1'b0;
		if (cfg == CFG_OFF) begin
			m.phases = 2'd0;
		end else if (!ps.power_state_bit_low0 && !ps.power_state_bit_low1) begin
			m.phases = 2'd1;
			m.diode_emulation = 1'b1;
		end else if (!ps.power_state_bit_low0) begin
			m.phases = (cfg == CFG_1PH) ? 2'd1 : 2'(cfg) - 2'd1;
		end else begin
			m.phases = 2'(cfg);
		end
		return m;
	endfunction

	ps_cmd_t ps_latched;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ps_latched <= '{1'b1, 1'b1};
		end else if (ps_cmd_valid) begin
			ps_latched <= ps_cmd;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			main_mode <= '0;
			aux_mode <= '0;
		end else if (strap_state == ST_RUN) begin
			main_mode <= pick_mode(cfg_main, ps_latched);
			aux_mode <= pick_mode(cfg_aux, ps_latched);
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_main_en
			assign main_phase_en[gp] = (main_mode.phases > 2'(gp));
		end
		for (gp = 0; gp < 2; gp++) begin : g_aux_en
			assign aux_phase_en[gp] = (aux_mode.phases > 2'(gp));
		end
	endgenerate

	// Extra compensator capacitor exists only in the two-phase main build
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			feedback_switch_close <= 1'b0;
			aux_feedback_track <= 1'b0;
		end else begin
			feedback_switch_close <= (cfg_main == CFG_2PH) && (main_mode.phases == 2'd2);
			aux_feedback_track <= (cfg_main == CFG_2PH) && (main_mode.phases != 2'd2);
		end
	end

	// Per-output logic: overcurrent, reference slewing, zero-cross tuning
	logic [15:0] slew_cyc;
	logic [11:0] cur_mon [2];
	logic [VID_W-1:0] vid_in [2];
	logic [VID_W-1:0] ref_v [2];
	logic [5:0] zc_thr [2];
	logic [1:0] emu_active;
	assign cur_mon[0] = main_current_monitor;
	assign cur_mon[1] = aux_current_monitor;
	assign vid_in[0] = vid_main;
	assign vid_in[1] = vid_aux;
	assign emu_active = {aux_mode.diode_emulation, main_mode.diode_emulation};

	genvar go;
	generate
		for (go = 0; go < 2; go++) begin : g_out
			logic [VID_W-1:0] target;
			logic [15:0] slew_tmr;
			logic ls_prev;
			logic meas;
			logic [5:0] win_cnt;
			logic [5:0] fwd_cnt;
			logic rev_seen;

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					oc_detect[go] <= 1'b0;
				end else begin
					oc_detect[go] <= (cur_mon[go] >= OC_THRESH_MV);
				end
			end

			// Up-steps move one code per slew interval; down-steps release the
			// reference at once and let the load discharge the output.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					target <= '0;
					ref_v[go] <= '0;
					slew_tmr <= '0;
					decay_active[go] <= 1'b0;
				end else begin
					if (vid_valid) begin
						target <= vid_in[go];
					end
					if (target > ref_v[go]) begin
						if (slew_tmr >= slew_cyc) begin
							slew_tmr <= '0;
							ref_v[go] <= ref_v[go] + 1'b1;
						end else begin
							slew_tmr <= slew_tmr + 16'd1;
						end
					end else begin
						slew_tmr <= '0;
					end
					if (target < ref_v[go]) begin
						ref_v[go] <= target;
						decay_active[go] <= 1'b1;
					end else if (!vabove_s[go]) begin
						decay_active[go] <= 1'b0;
					end
				end
			end

			assign low_side_off_req[go] = emu_active[go] && low_side_on[go] && zc_s[go];

			// Diode conduction is measured in a fixed window after each low-side turn-off in diode emulation
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					ls_prev <= 1'b0;
					meas <= 1'b0;
					win_cnt <= '0;
					fwd_cnt <= '0;
					rev_seen <= 1'b0;
					zc_thr[go] <= ZC_THR_RST;
				end else begin
					ls_prev <= low_side_on[go];
					if (emu_active[go] && ls_prev && !low_side_on[go]) begin
						meas <= 1'b1;
						win_cnt <= '0;
						fwd_cnt <= '0;
						rev_seen <= 1'b0;
					end else if (meas) begin
						win_cnt <= win_cnt + 6'd1;
						if (fwd_s[go] && fwd_cnt != 6'h3f) begin
							fwd_cnt <= fwd_cnt + 6'd1;
						end
						if (rev_s[go]) begin
							rev_seen <= 1'b1;
						end
						if (win_cnt == 6'(MEAS_WIN_CYC - 1)) begin
							meas <= 1'b0;
							if (rev_seen && zc_thr[go] != ZC_THR_MAX) begin
								zc_thr[go] <= zc_thr[go] + 6'd1;
							end else if (!rev_seen && fwd_cnt > 6'(BODY_DIODE_CYC)
								&& zc_thr[go] != 6'h00) begin
								zc_thr[go] <= zc_thr[go] - 6'd1;
							end else if (!rev_seen && fwd_cnt < 6'(BODY_DIODE_CYC)
								&& zc_thr[go] != ZC_THR_MAX) begin
								zc_thr[go] <= zc_thr[go] + 6'd1;
							end
						end
					end
				end
			end
		end
	endgenerate

	assign ref_main = ref_v[0];
	assign ref_aux = ref_v[1];
	assign zc_thr_main = zc_thr[0];
	assign zc_thr_aux = zc_thr[1];

	// AXI4-Lite slave; address and data may arrive in either order
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [1:0] oc_sticky;
	wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
	wire logic wr_ok = (aw_addr == CTRL_OFS) || (aw_addr == OC_FLAG_OFS);

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slew_cyc <= SLEW_CYC_RST;
		end else if (wr_go && aw_addr == CTRL_OFS) begin
			if (w_strb[0]) begin
				slew_cyc[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				slew_cyc[15:8] <= w_data[15:8];
			end
		end
	end

	// A new overcurrent event beats a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oc_sticky <= '0;
		end else if (wr_go && aw_addr == OC_FLAG_OFS && w_strb[0]) begin
			oc_sticky <= (oc_sticky & ~w_data[1:0]) | oc_detect;
		end else begin
			oc_sticky <= oc_sticky | oc_detect;
		end
	end

	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		case ({s_axi_araddr[7:2], 2'b00})
			CTRL_OFS: rd_word[15:0] = slew_cyc;
			STATUS_OFS: begin
				rd_word[ST_CFG_MAIN +: 2] = cfg_main;
				rd_word[ST_CFG_AUX +: 2] = cfg_aux;
				rd_word[ST_PH_MAIN +: 2] = main_mode.phases;
				rd_word[ST_EMU_MAIN] = main_mode.diode_emulation;
				rd_word[ST_PH_AUX +: 2] = aux_mode.phases;
				rd_word[ST_EMU_AUX] = aux_mode.diode_emulation;
				rd_word[ST_SW_CLOSED] = feedback_switch_close;
				rd_word[ST_RUN_BIT] = switching_enable;
				rd_word[ST_OC +: 2] = oc_sticky;
			end
			OC_FLAG_OFS: rd_word[1:0] = oc_sticky;
			ZC_THR_OFS: begin
				rd_word[5:0] = zc_thr[0];
				rd_word[ZC_AUX_POS +: 6] = zc_thr[1];
			end
			REF_OFS: begin
				rd_word[VID_W-1:0] = ref_v[0];
				rd_word[REF_AUX_POS +: VID_W] = ref_v[1];
			end
			default: rd_word = '0;
		endcase
	end

	wire logic rd_hit = ({s_axi_araddr[7:2], 2'b00} inside {CTRL_OFS, STATUS_OFS,
		OC_FLAG_OFS, ZC_THR_OFS, REF_OFS}) && (s_axi_araddr[31:8] == '0);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	AST_MAIN_OFF: assert property (@(posedge clk) disable iff (!nrst)
		cfg_main == CFG_OFF |-> main_phase_en == 3'b000)
		else $error("Main output active while strapped off");

	AST_AUX_OFF: assert property (@(posedge clk) disable iff (!nrst)
		cfg_aux == CFG_OFF |-> aux_phase_en == 2'b00)
		else $error("Aux output active while strapped off");

	AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		strap_state == ST_RUN |=> $stable(cfg_main) && $stable(cfg_aux))
		else $error("Phase config changed after capture");

	AST_EMU_ONE_PHASE: assert property (@(posedge clk) disable iff (!nrst)
		main_mode.diode_emulation |-> main_phase_en == 3'b001)
		else $error("Diode emulation with more than one phase");

	AST_SHED_3PH: assert property (@(posedge clk) disable iff (!nrst)
		strap_state == ST_RUN && cfg_main == CFG_3PH && ps_latched == 2'b01
		|=> main_phase_en == 3'b011 && !main_mode.diode_emulation)
		else $error("Three-phase config did not shed to two phases");

	AST_ONE_PH_CCM: assert property (@(posedge clk) disable iff (!nrst)
		strap_state == ST_RUN && cfg_main == CFG_1PH && ps_latched != 2'b00
		|=> main_phase_en == 3'b001 && !main_mode.diode_emulation)
		else $error("One-phase config left continuous conduction");

	AST_FEEDBACK_SW: assert property (@(posedge clk) disable iff (!nrst)
		feedback_switch_close |-> !aux_feedback_track && $past(cfg_main) == CFG_2PH)
		else $error("Feedback switch closed outside two-phase build");

	AST_OC: assert property (@(posedge clk) disable iff (!nrst)
		main_current_monitor >= OC_THRESH_MV |=> oc_detect[0] ##1 oc_sticky[0])
		else $error("Main overcurrent not flagged");

	AST_DOWN_STEP: assert property (@(posedge clk) disable iff (!nrst)
		g_out[0].target < ref_v[0] |=> ref_v[0] == $past(g_out[0].target) && decay_active[0])
		else $error("Downward step not released to load decay");

	AST_ZC_OFF: assert property (@(posedge clk) disable iff (!nrst)
		main_mode.diode_emulation && low_side_on[0] && sync2[7] |-> low_side_off_req[0])
		else $error("Zero cross did not end low-side on-time");

endmodule

// [testbench/vr_host_model.sv]
`timescale 1ns/100ps
module vr_host_model
	import vr_phase_mode_pkg::*;
#(
	parameter int VID_W = 8
) (
	input wire logic clk,
	output ps_cmd_t ps_cmd,
	output logic ps_cmd_valid,
	output logic [VID_W-1:0] vid_main,
	output logic [VID_W-1:0] vid_aux,
	output logic vid_valid
);
	initial begin
		ps_cmd = 2'h3;
		ps_cmd_valid = 1'h0;
		vid_main = '0;
		vid_aux = '0;
		vid_valid = 1'h0;
	end

	// Released lines show the inverse, so a latch taken off the strobe cannot hide
	task automatic send_ps(input logic [1:0] code);
		@(posedge clk);
		ps_cmd <= code;
		ps_cmd_valid <= 1'h1;
		@(posedge clk);
		ps_cmd_valid <= 1'h0;
		ps_cmd <= ~code;
	endtask

	task automatic send_vid(input logic [VID_W-1:0] vm, input logic [VID_W-1:0] va);
		@(posedge clk);
		vid_main <= vm;
		vid_aux <= va;
		vid_valid <= 1'h1;
		@(posedge clk);
		vid_valid <= 1'h0;
		vid_main <= ~vm;
		vid_aux <= ~va;
	endtask
endmodule

// [testbench/vr_phase_mode_select_tb_top.sv]
`timescale 1ns/100ps
module vr_phase_mode_select_tb_top
	import vr_phase_mode_pkg::*;
;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic main_phase1_sense = 1'h0, main_phase2_sense = 1'h0, main_phase3_sense = 1'h0;
	logic aux_phase1_sense = 1'h0, aux_phase2_sense = 1'h0;
	ps_cmd_t ps_cmd;
	logic ps_cmd_valid, vid_valid;
	logic [7:0] vid_main, vid_aux, ref_main, ref_aux;
	logic [11:0] main_current_monitor = '0, aux_current_monitor = '0;
	logic [1:0] vout_above_target = 2'h3, low_side_on = 2'h3, zero_cross_cmp = 2'h3;
	logic [1:0] diode_fwd_cond = 2'h0, diode_rev_spike = 2'h0;
	logic switching_enable, feedback_switch_close, aux_feedback_track;
	logic [2:0] main_phase_en;
	logic [1:0] aux_phase_en, oc_detect, decay_active, low_side_off_req;
	op_mode_t main_mode, aux_mode;
	logic [5:0] zc_thr_main, zc_thr_aux;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	// Strap order {main1, main2, main3, aux1, aux2}; configs 3+2, 2+1, 1+off, off+2
	localparam logic [4:0] STRAPS [4] = '{5'h00, 5'h05, 5'h0e, 5'h10};
	localparam int MAIN_N [4] = '{3, 2, 1, 0};
	localparam int AUX_N [4] = '{2, 1, 0, 2};

	vr_host_model #(.VID_W(8)) vr_host_model_i (.clk(clk), .ps_cmd(ps_cmd),
		.ps_cmd_valid(ps_cmd_valid), .vid_main(vid_main), .vid_aux(vid_aux),
		.vid_valid(vid_valid));

	vr_phase_mode_select #(.VID_W(8)) vr_phase_mode_select_i (.clk(clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.main_phase1_sense(main_phase1_sense), .main_phase2_sense(main_phase2_sense),
		.main_phase3_sense(main_phase3_sense), .aux_phase1_sense(aux_phase1_sense),
		.aux_phase2_sense(aux_phase2_sense), .ps_cmd(ps_cmd), .ps_cmd_valid(ps_cmd_valid),
		.vid_main(vid_main), .vid_aux(vid_aux), .vid_valid(vid_valid),
		.main_current_monitor(main_current_monitor), .aux_current_monitor(aux_current_monitor),
		.vout_above_target(vout_above_target), .low_side_on(low_side_on),
		.zero_cross_cmp(zero_cross_cmp), .diode_fwd_cond(diode_fwd_cond),
		.diode_rev_spike(diode_rev_spike), .switching_enable(switching_enable),
		.main_phase_en(main_phase_en), .aux_phase_en(aux_phase_en), .main_mode(main_mode),
		.aux_mode(aux_mode), .feedback_switch_close(feedback_switch_close),
		.aux_feedback_track(aux_feedback_track), .oc_detect(oc_detect), .ref_main(ref_main),
		.ref_aux(ref_aux), .decay_active(decay_active), .low_side_off_req(low_side_off_req),
		.zc_thr_main(zc_thr_main), .zc_thr_aux(zc_thr_aux));

	always #2 clk = ~clk;

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Whole run is well under a thousand cycles; this only catches a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic restart(input logic [4:0] s);
		@(posedge clk);
		nrst <= 1'h0;
		{main_phase1_sense, main_phase2_sense, main_phase3_sense} <= s[4:2];
		{aux_phase1_sense, aux_phase2_sense} <= s[1:0];
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		for (int i = 0; i < 50 && switching_enable !== 1'h1; i++) @(posedge clk);
		ticks(2);
	endtask

	task automatic zc_event(input logic fwd, input logic rev);
		@(posedge clk);
		diode_fwd_cond <= {1'h0, fwd};
		diode_rev_spike <= {1'h0, rev};
		low_side_on <= 2'h2;
		repeat (MEAS_WIN_CYC + 8) @(posedge clk);
		low_side_on <= 2'h3;
		diode_fwd_cond <= 2'h0;
		diode_rev_spike <= 2'h0;
		ticks(4);
	endtask

	function automatic int exp_ph(input int n, input logic [1:0] c);
		if (n == 0) return 0;
		if (c == 2'h0) return 1;
		if (c == 2'h1) return (n == 3) ? 2 : 1;
		return n;
	endfunction

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] c;
		int nm, na, ph, pa, t0;
		for (int k = 0; k < 4; k++) begin
			nm = MAIN_N[k];
			na = AUX_N[k];
			restart(STRAPS[k]);
			// Flip straps after start-up: a design that resamples them would change config
			@(posedge clk);
			{main_phase1_sense, main_phase2_sense, main_phase3_sense} <= ~STRAPS[k][4:2];
			{aux_phase1_sense, aux_phase2_sense} <= ~STRAPS[k][1:0];
			axi_rd({24'h0, STATUS_OFS}, d, r);
			check(d[3:0], {na[1:0], nm[1:0]});
			check(d[11], 1'h1);
			check(r, 2'h0);
			check(switching_enable, 1'h1);
			for (int j = 3; j >= 0; j--) begin
				c = j[1:0];
				vr_host_model_i.send_ps(c);
				ticks(3);
				ph = exp_ph(nm, c);
				pa = exp_ph(na, c);
				check(main_mode, {ph[1:0], nm != 0 && c == 2'h0});
				check(aux_mode, {pa[1:0], na != 0 && c == 2'h0});
				check(main_phase_en, (1 << ph) - 1);
				check(aux_phase_en, (1 << pa) - 1);
				check(feedback_switch_close, nm == 2 && ph == 2);
				check(aux_feedback_track, nm == 2 && ph != 2);
				check(low_side_off_req, {na != 0 && c == 2'h0, nm != 0 && c == 2'h0});
			end
			@(posedge clk);
			main_current_monitor <= OC_THRESH_MV;
			aux_current_monitor <= OC_THRESH_MV - 12'h1;
			ticks(3);
			check(oc_detect, 2'h1);
			@(posedge clk);
			main_current_monitor <= OC_THRESH_MV - 12'h1;
			aux_current_monitor <= OC_THRESH_MV;
			ticks(3);
			check(oc_detect, 2'h2);
			@(posedge clk);
			aux_current_monitor <= 12'h0;
			if (k == 0) begin
				// Both sticky flags are set now; clearing one must leave the other
				axi_rd({24'h0, OC_FLAG_OFS}, d, r);
				check(d[1:0], 2'h3);
				axi_wr({24'h0, OC_FLAG_OFS}, 32'h1, r);
				axi_rd({24'h0, OC_FLAG_OFS}, d, r);
				check(d[1:0], 2'h2);
				// Still in diode emulation from the last command of the loop
				zc_event(1'h1, 1'h0);
				check(zc_thr_main, ZC_THR_RST - 6'h1);
				zc_event(1'h0, 1'h0);
				check(zc_thr_main, ZC_THR_RST);
				zc_event(1'h0, 1'h1);
				check(zc_thr_main, ZC_THR_RST + 6'h1);
				check(zc_thr_aux, ZC_THR_RST);
				axi_rd({24'h0, ZC_THR_OFS}, d, r);
				check(d[13:0], {ZC_THR_RST, 2'h0, ZC_THR_RST + 6'h1});
				axi_rd({24'h0, CTRL_OFS}, d, r);
				check(d[15:0], SLEW_CYC_RST);
				axi_wr({24'h0, CTRL_OFS}, 32'h3, r);
				check(r, 2'h0);
				axi_wr(32'h20, 32'h5, r);
				check(r, 2'h2);
				axi_rd(32'h14, d, r);
				check(r, 2'h2);
				check(d, 32'h0);
				axi_rd({24'h0, CTRL_OFS}, d, r);
				check(d[15:0], 16'h3);
				// Six codes at one step per four cycles: about 24 cycles, never a jump
				vr_host_model_i.send_vid(8'h6, 8'h6);
				t0 = 0;
				while (ref_main !== 8'h6 && t0 < 200) begin
					ticks(1);
					t0++;
				end
				check(t0 >= 21 && t0 <= 27, 1'h1);
				check(ref_aux, 8'h6);
				vr_host_model_i.send_vid(8'h2, 8'h2);
				ticks(2);
				check({ref_aux, ref_main}, 16'h0202);
				check(decay_active, 2'h3);
				@(posedge clk);
				vout_above_target <= 2'h0;
				ticks(4);
				check(decay_active, 2'h0);
				axi_rd({24'h0, REF_OFS}, d, r);
				check(d[15:0], 16'h0202);
				@(posedge clk);
				vout_above_target <= 2'h3;
			end
		end
		summarize();
	end
endmodule
